// >>> logic/xmb_params.svh
`ifndef XMB_PARAMS_SVH
`define XMB_PARAMS_SVH
// bus register offsets and control register fields
`define XMB_REG_CTRL 4'h0
`define XMB_REG_STAT 4'h1
`define XMB_REG_RDATA 4'h2
`define XMB_CTRL_RESET 8'h00
`define XMB_BIT_DIS 7
`define XMB_WAIT_HI 5
`define XMB_WAIT_LO 4
`define XMB_WM_HI 1
`define XMB_WM_LO 0
// control port bit positions
`define XMB_CP_ALE 0
`define XMB_CP_OE 1
`define XMB_CP_WRL 2
`define XMB_CP_WRH 3
`define XMB_CP_BA0 4
`define XMB_CP_CE 5
`define XMB_CP_LB 6
`define XMB_CP_UB 7
`define XMB_FIFO_DEPTH 16
`endif

// >>> logic/xmb_pkg.sv
package xmb_pkg;
  typedef enum logic [1:0] {xmb_amode_mcu, xmb_amode_a12, xmb_amode_a16, xmb_amode_a20} xmb_amode_e;
  typedef enum logic [2:0] {xmb_st_idle, xmb_st_addr, xmb_st_data, xmb_st_wait, xmb_st_done}
    xmb_state_e;
endpackage

// >>> logic/xmb_fifo.sv
`timescale 1ns/10ps
module xmb_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic i_clk, // clock
  input wire logic i_rst_b, // async reset, low
  input wire logic i_in_valid, // fill valid
  output logic o_in_ready, // fill ready
  input wire logic [WIDTH-1:0] i_in_data, // fill data
  output logic o_out_valid, // drain valid
  input wire logic i_out_ready, // drain ready
  output logic [WIDTH-1:0] o_out_data // drain data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;
  assign o_in_ready = (count != (AW+1)'(DEPTH));
  assign o_out_valid = (count != '0);
  assign o_out_data = mem[rd_ptr];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  always_ff @(posedge i_clk)
  begin
    if (push)
      mem[wr_ptr] <= i_in_data;
  end
endmodule

// >>> logic/xmb_ctrl.sv
// Design decisions made here: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
`include "xmb_params.svh"
// Behaviour
// - 8/16-bit data, 12/16/20-bit address widths
// - 28 pins across four shared ports
// - lines 0-15 multiplexed, 16-19 address only
// - mux low/high ports, upper address port
// - control port bits 0-5 strobe assignment
// - byte enables on control bits 6, 7
// - control register ignores writes in mcu mode
// - disable bit clear: bus owns pins outside mcu mode
// - disable bit set: bus takes pins per access
// - disable bit clears at reset
// - wait states from wait-count field
// - write mode ignored in 8-bit width
// - wait codes 11,10,01,00 give 0..3
// - word, byte-select and byte-write modes
// - waits only when wait option enabled
module xmb_ctrl
  import xmb_pkg::*;
#(
  parameter int FIFO_DEPTH = `XMB_FIFO_DEPTH
) (
  input wire logic i_clk, // 100 MHz instruction clock
  input wire logic i_rst_b, // async reset, low
  input wire logic i_wide_data, // strap: 1 = 16-bit data
  input wire xmb_pkg::xmb_amode_e i_amode, // strap: address mode
  input wire logic i_wait_en, // strap: wait states enabled
  input wire logic [3:0] i_reg_addr, // register address
  input wire logic [7:0] i_reg_wdata, // register write data
  input wire logic i_reg_wr, // register write strobe
  input wire logic i_reg_rd, // register read strobe
  output logic [7:0] o_reg_rdata, // read data, next cycle
  input wire logic i_tbl_valid, // table op request
  output logic o_tbl_ready, // request queue has room
  input wire logic i_tbl_write, // 1 = table write
  input wire logic [20:0] i_tbl_addr, // byte address
  input wire logic [7:0] i_tbl_data, // table data latch byte
  output logic o_rd_valid, // table read data pulse
  output logic [7:0] o_rd_data, // table read byte
  input wire logic [7:0] i_low_mux_port, // low mux port pins in
  input wire logic [7:0] i_high_mux_port, // high mux port pins in
  output logic [7:0] o_low_mux_port, // low mux port out
  output logic [7:0] o_high_mux_port, // high mux port out
  output logic [3:0] o_upper_addr_port, // upper address out
  output logic [7:0] o_bus_control_port, // control strobes, low active except ALE on bit 0
  output logic o_mux_oe_b, // mux lines output enable, low
  output logic [3:0] o_bus_own, // bus owns: low, high, upper, ctrl
  output logic o_busy // access in progress
);
  import xmb_pkg::*;
  localparam int QW = 30;
  // =====================================================================
  // state
  // =====================================================================
  typedef struct packed {
    xmb_state_e st;
    logic [7:0] ctrl;
    logic [1:0] wcnt;
    logic [29:0] op;
    logic [7:0] lo_out;
    logic [7:0] hi_out;
    logic [3:0] up_out;
    logic [7:0] cport;
    logic oe_b;
    logic [3:0] own;
    logic [7:0] rbuf;
    logic rd_valid;
    logic [1:0] cap;
    logic [7:0] rdata;
    logic busy;
  } xmb_state_s;
  xmb_state_s r;
  xmb_state_s next_r;
  logic q_valid;
  logic [QW-1:0] q_data;
  logic q_pop;
  logic sel_low;
  logic [1:0] wm;
  logic [1:0] waits;
  logic [7:0] cp_idle;
  logic [7:0] mux_lo;
  logic [7:0] mux_hi;
  logic [7:0] lo_s1;
  logic [7:0] lo_s2;
  logic [7:0] hi_s1;
  logic [7:0] hi_s2;
  // =====================================================================
  // request queue
  // =====================================================================
  xmb_fifo #(.WIDTH(QW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_in_valid(i_tbl_valid),
    .o_in_ready(o_tbl_ready),
    .i_in_data({i_tbl_write, i_tbl_addr, i_tbl_data}),
    .o_out_valid(q_valid),
    .i_out_ready(q_pop),
    .o_out_data(q_data)
  );
  assign q_pop = (r.st == xmb_st_idle) && q_valid && (i_amode != xmb_amode_mcu);
  // =====================================================================
  // bus sequencer
  // =====================================================================
  always_comb
  begin
    next_r = r;
    next_r.rd_valid = 1'b0;
    wm = r.ctrl[`XMB_WM_HI:`XMB_WM_LO];
    waits = i_wait_en ? ~r.ctrl[`XMB_WAIT_HI:`XMB_WAIT_LO] : 2'h0;
    sel_low = ~r.op[8];
    cp_idle = 8'hfe;
    mux_lo = r.op[7:0];
    mux_hi = r.op[7:0];
    // read byte comes from the second sync stage, two edges after strobe end
    next_r.cap = {r.cap[0], 1'b0};
    if (r.cap[1])
    begin
      next_r.rbuf = (i_wide_data && !sel_low) ? hi_s2 : lo_s2;
      next_r.rd_valid = 1'b1;
    end
    if (i_reg_wr && i_reg_addr == `XMB_REG_CTRL && i_amode != xmb_amode_mcu)
      next_r.ctrl = i_reg_wdata & 8'hb3;
    if (i_reg_rd)
      unique case (i_reg_addr)
        `XMB_REG_CTRL: next_r.rdata = r.ctrl;
        `XMB_REG_STAT: next_r.rdata = {7'h00, r.busy};
        `XMB_REG_RDATA: next_r.rdata = r.rbuf;
        default: next_r.rdata = 8'h00;
      endcase
    // outside mcu mode, pins held by bus when disable bit clear, else only during access
    next_r.own = (r.ctrl[`XMB_BIT_DIS] && r.st == xmb_st_idle && !q_pop) ? 4'h0 :
      {1'b1, i_amode == xmb_amode_a20, i_amode != xmb_amode_mcu, 1'b1};
    if (i_amode == xmb_amode_mcu)
      next_r.own = 4'h0;
    unique case (r.st)
      xmb_st_idle:
      begin
        next_r.cport = cp_idle;
        next_r.oe_b = 1'b1;
        next_r.busy = 1'b0;
        if (q_pop)
        begin
          next_r.op = q_data;
          next_r.st = xmb_st_addr;
          next_r.busy = 1'b1;
          // word address on lines in 16-bit mode, byte address in 8-bit; byte lsb on its own strobe
          next_r.lo_out = i_wide_data ? q_data[16:9] : q_data[15:8];
          next_r.hi_out = i_wide_data ? q_data[24:17] : q_data[23:16];
          next_r.up_out = i_wide_data ? q_data[28:25] : q_data[27:24];
          next_r.oe_b = 1'b0;
          next_r.cport = cp_idle;
          next_r.cport[`XMB_CP_ALE] = 1'b1;
          next_r.cport[`XMB_CP_CE] = 1'b0;
          next_r.cport[`XMB_CP_BA0] = q_data[8];
        end
      end
      xmb_st_addr:
      begin
        next_r.cport[`XMB_CP_ALE] = 1'b0;
        if (r.op[29])
        begin
          next_r.oe_b = 1'b0;
          if (!i_wide_data)
          begin
            next_r.lo_out = r.op[7:0];
            next_r.cport[`XMB_CP_WRL] = 1'b0;
          end
          else if (wm[1])
          begin
            next_r.lo_out = sel_low ? r.op[7:0] : mux_lo;
            next_r.hi_out = mux_hi;
            next_r.cport[sel_low ? `XMB_CP_WRL : `XMB_CP_WRH] = 1'b0;
          end
          else if (wm == 2'b01)
          begin
            next_r.lo_out = r.op[7:0];
            next_r.hi_out = r.op[7:0];
            next_r.cport[`XMB_CP_WRH] = 1'b0;
            next_r.cport[sel_low ? `XMB_CP_LB : `XMB_CP_UB] = 1'b0;
          end
          else
          begin
            next_r.lo_out = r.op[7:0];
            next_r.hi_out = r.op[7:0];
            next_r.cport[sel_low ? `XMB_CP_WRL : `XMB_CP_WRH] = 1'b0;
          end
        end
        else
        begin
          next_r.oe_b = 1'b1;
          next_r.cport[`XMB_CP_OE] = 1'b0;
          if (i_wide_data)
          begin
            next_r.cport[`XMB_CP_LB] = 1'b0;
            next_r.cport[`XMB_CP_UB] = 1'b0;
          end
        end
        next_r.wcnt = waits;
        next_r.st = xmb_st_data;
      end
      xmb_st_data:
      begin
        if (r.wcnt == 2'h0)
        begin
          // pins still driven at this edge, first sync stage takes them
          if (!r.op[29])
            next_r.cap[0] = 1'b1;
          next_r.cport = cp_idle;
          next_r.cport[`XMB_CP_CE] = 1'b0;
          next_r.st = xmb_st_done;
        end
        else
          next_r.wcnt = r.wcnt - 2'h1;
      end
      xmb_st_done:
      begin
        next_r.cport = cp_idle;
        next_r.oe_b = 1'b1;
        next_r.st = xmb_st_idle;
      end
      default: next_r.st = xmb_st_idle;
    endcase
  end
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      r <= '0;
      r.st <= xmb_st_idle;
      r.ctrl <= `XMB_CTRL_RESET;
      r.cport <= 8'hfe;
      r.oe_b <= 1'b1;
      r.own <= 4'hf;
    end
    else
      r <= next_r;
  end
  // read port: pins pass two flops before use
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      lo_s1 <= 8'h00;
      lo_s2 <= 8'h00;
      hi_s1 <= 8'h00;
      hi_s2 <= 8'h00;
    end
    else
    begin
      lo_s1 <= i_low_mux_port;
      lo_s2 <= lo_s1;
      hi_s1 <= i_high_mux_port;
      hi_s2 <= hi_s1;
    end
  end
  assign o_low_mux_port = r.lo_out;
  assign o_high_mux_port = r.hi_out;
  assign o_upper_addr_port = r.up_out;
  assign o_bus_control_port = r.cport;
  assign o_mux_oe_b = r.oe_b;
  assign o_bus_own = r.own;
  assign o_busy = r.busy;
  assign o_reg_rdata = r.rdata;
  assign o_rd_valid = r.rd_valid;
  assign o_rd_data = r.rbuf;
  // =====================================================================
  // checks
  // =====================================================================
  sequence s_addr_phase;
    r.st == xmb_st_addr && r.cport[`XMB_CP_ALE];
  endsequence
  sequence s_data_phase;
    !r.cport[`XMB_CP_ALE] && (!r.cport[`XMB_CP_OE] || !r.cport[`XMB_CP_WRL] ||
      !r.cport[`XMB_CP_WRH]);
  endsequence
  // end of a read data phase: last data-state cycle of a read, wait count zero
  sequence s_read_end;
    r.st == xmb_st_data && r.wcnt == 2'h0 && !r.op[29];
  endsequence
  chk_read_capture: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    s_read_end |=> ##2 r.rd_valid)
    else $error("read byte not handed over after data phase");
  chk_rd_pulse: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    r.rd_valid |=> !r.rd_valid)
    else $error("read valid longer than one cycle");
  chk_ale_single: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    r.cport[`XMB_CP_ALE] |=> !r.cport[`XMB_CP_ALE])
    else $error("latch strobe longer than one cycle");
  chk_idle_strobes: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    r.st == xmb_st_idle |-> r.cport[3:1] == 3'b111)
    else $error("strobe active while idle");
  chk_ce_held: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    r.st == xmb_st_data |-> !r.cport[`XMB_CP_CE])
    else $error("chip enable dropped in data phase");
  chk_mcu_pins_free: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_amode == xmb_amode_mcu) |=> r.own == 4'h0)
    else $error("bus holds pins in mcu mode");
  chk_disable_free: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (r.ctrl[`XMB_BIT_DIS] && r.st == xmb_st_idle && !q_pop) |=> r.own == 4'h0)
    else $error("bus kept pins while disabled and idle");
  chk_byte_en_read: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (r.st == xmb_st_addr && !r.op[29] && i_wide_data) |=>
      !r.cport[`XMB_CP_LB] && !r.cport[`XMB_CP_UB])
    else $error("byte enables not active on wide read");
  chk_wait_off: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (r.st == xmb_st_addr && !i_wait_en) |=> r.wcnt == 2'h0)
    else $error("wait loaded while waits disabled");
  chk_word_one_strobe: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (r.st == xmb_st_addr && r.op[29] && i_wide_data && r.ctrl[1]) |=>
      r.cport[`XMB_CP_WRL] != r.cport[`XMB_CP_WRH])
    else $error("word write did not use one lane strobe");
  chk_addr_then_data: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    s_addr_phase |=> s_data_phase)
    else $error("data phase did not follow address phase");
  chk_reset_bus_on: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    $rose(i_rst_b) |-> !r.ctrl[`XMB_BIT_DIS])
    else $error("bus disable not clear after reset");
  chk_mcu_no_write: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_amode == xmb_amode_mcu) |=> $stable(r.ctrl))
    else $error("control written in mcu mode");
  chk_own_enabled: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (!r.ctrl[`XMB_BIT_DIS] && i_amode == xmb_amode_a20 && $stable(i_amode)) |=> r.own == 4'hf)
    else $error("bus released pins while enabled");
  chk_wait_zero: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (r.st == xmb_st_addr && (!i_wait_en || r.ctrl[5:4] == 2'b11)) |=> ##1 r.st == xmb_st_done)
    else $error("zero wait code inserted a delay");
  chk_wait_three: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (r.st == xmb_st_addr && i_wait_en && r.ctrl[5:4] == 2'b00) |=>
      (r.st == xmb_st_data)[*4] ##1 r.st == xmb_st_done)
    else $error("wait code 00 did not give three cycles");
  chk_byte_sel_copy: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (r.st == xmb_st_addr && r.op[29] && i_wide_data && r.ctrl[1:0] == 2'b01) |=>
      r.lo_out == r.hi_out && !r.cport[`XMB_CP_WRH])
    else $error("byte select mode did not copy byte");
  chk_narrow_wrl: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (r.st == xmb_st_addr && r.op[29] && !i_wide_data) |=>
      !r.cport[`XMB_CP_WRL] && r.cport[`XMB_CP_WRH])
    else $error("8-bit write used wrong strobe");
endmodule

// >>> verification/xmb_mem_model.sv
`timescale 1ns/10ps
// ==========================================
// external memory answering on the mux lines
module xmb_mem_model (
  input wire logic i_clk, // clock
  input wire logic [7:0] i_lo, // low mux lines from bus
  input wire logic [7:0] i_hi, // high mux lines from bus
  input wire logic [3:0] i_up, // upper address lines
  input wire logic [7:0] i_ctrl, // control strobes
  output logic [7:0] o_lo, // low mux lines to bus
  output logic [7:0] o_hi // high mux lines to bus
);
  logic [19:0] word_addr = 20'h00000;
  logic [15:0] last = 16'h0000;
  logic drive;
  logic [15:0] word;
  // answer only while selected and output enabled
  assign drive = !i_ctrl[1] && !i_ctrl[5];
  assign word = {word_addr[15:8] ^ 8'ha5, word_addr[7:0] ^ 8'h5a};
  // released lines toggle, showing the inverse of the previous cycle's value
  assign {o_hi, o_lo} = drive ? word : ~last;
  always @(posedge i_clk)
  begin
    if (i_ctrl[0])
      word_addr <= {i_up, i_hi, i_lo};
    last <= {o_hi, o_lo};
  end
endmodule

// >>> verification/external_memory_bus_ctrl_test.sv
`timescale 1ns/10ps
module external_memory_bus_ctrl_test;
  import xmb_pkg::*;
  logic i_clk = 1'b0, i_rst_b = 1'b0, wait_en = 1'b1, wr = 1'b0, rd = 1'b0;
  logic tv = 1'b0, tw = 1'b0, tready, rd_valid, mux_oe_b, busy, pend = 1'b0, wide = 1'b1;
  bit h;
  xmb_amode_e amode = xmb_amode_a20;
  logic [3:0] ra = 4'h0, up, own;
  logic [7:0] wd = 8'h00, td = 8'h00, rdata, rd_data, lo, hi, mlo, mhi, cp;
  logic [20:0] ta = 21'h000000;
  logic [7:0] q[$];
  int errors = 0, checks = 0, cnt[4], n;
  xmb_ctrl uut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_wide_data(wide), .i_amode(amode),
    .i_wait_en(wait_en), .i_reg_addr(ra), .i_reg_wdata(wd), .i_reg_wr(wr), .i_reg_rd(rd),
    .o_reg_rdata(rdata), .i_tbl_valid(tv), .o_tbl_ready(tready), .i_tbl_write(tw),
    .i_tbl_addr(ta), .i_tbl_data(td), .o_rd_valid(rd_valid), .o_rd_data(rd_data),
    .i_low_mux_port(mlo), .i_high_mux_port(mhi), .o_low_mux_port(lo), .o_high_mux_port(hi),
    .o_upper_addr_port(up), .o_bus_control_port(cp), .o_mux_oe_b(mux_oe_b), .o_bus_own(own),
    .o_busy(busy));
  xmb_mem_model mem (.i_clk(i_clk), .i_lo(lo), .i_hi(hi), .i_up(up), .i_ctrl(cp), .o_lo(mlo),
    .o_hi(mhi));
  initial forever #5 i_clk = ~i_clk;
  // ==========================================
  // checking and closing
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // results are compared against the oldest note
  always @(posedge i_clk)
  begin
    if (pend || rd_valid)
      chk(pend ? rdata : rd_data, q.size() ? q.pop_front() : 8'hxx);
    pend = rd;
  end
  // ==========================================
  // bus tasks
  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk);
    wr <= 1'b1; ra <= a; wd <= d;
    @(posedge i_clk);
    wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge i_clk);
    q.push_back(e); rd <= 1'b1; ra <= a;
    @(posedge i_clk);
    rd <= 1'b0;
  endtask
  task automatic reset(input xmb_amode_e m);
    amode <= m; i_rst_b <= 1'b0;
    repeat (4) @(posedge i_clk);
    i_rst_b <= 1'b1;
  endtask
  task automatic step(output bit hit, input logic [2:0] sel);
    n = 0;
    do begin @(posedge i_clk); #1; n++; end
    while (!(sel == 0 ? cp[0] : sel == 1 ? cp[3:1] != 3'b111 : !busy) && n < 60);
    hit = n < 60;
    if (!hit) begin errors++; final_report(); end
  endtask
  // one table access, checking both phases, returns busy length
  task automatic tbl(input logic w, input logic [20:0] a, input logic [7:0] d, output int len);
    bit h;
    if (!w) q.push_back(a[0] ? a[16:9] ^ 8'ha5 : a[8:1] ^ 8'h5a);
    @(posedge i_clk);
    tv <= 1'b1; tw <= w; ta <= a; td <= d;
    n = 0;
    do begin @(posedge i_clk); n++; end while (!tready && n < 60);
    if (n >= 60) begin errors++; final_report(); end
    tv <= 1'b0;
    step(h, 0);
    len = n;
    chk({up, hi, lo, cp[4], cp[5], cp[1], mux_oe_b}, {a[20:17], a[16:1], a[0], 3'h2});
    step(h, 1);
    len += n;
    chk({cp[0], cp[1], cp[3:2]}, w ? {2'h1, a[0] ? 2'h1 : 2'h2} : 4'h3);
    if (w) chk({hi, lo}, {d, d});
    step(h, 2);
    len += n;
  endtask
  initial
  begin
    void'($urandom(27003));
    reset(xmb_amode_a20);
    chk({own, cp}, 12'hffe);
    reg_rd(4'h0, 8'h00);
    reg_rd(4'h7, 8'h00);
    reg_wr(4'h0, 8'hff);
    reg_rd(4'h0, 8'hb3);
    $display("registers done");
    reg_wr(4'h0, 8'h80);
    repeat (2) @(posedge i_clk);
    chk(own, 4'h0);
    for (int c = 3; c >= 0; c--)
    begin
      reg_wr(4'h0, {2'h2, c[1:0], 4'h0});
      tbl(1'b0, 21'($urandom), 8'h00, cnt[c]);
      chk(cnt[c] - cnt[3], 3 - c);
    end
    wait_en <= 1'b0;
    tbl(1'b1, 21'($urandom), 8'($urandom), n);
    chk(n, cnt[3]);
    wait_en <= 1'b1;
    $display("wait states done");
    reg_wr(4'h0, 8'h30);
    for (int k = 0; k < 4; k++) tbl(1'b1, 21'($urandom), 8'($urandom), n);
    $display("writes done");
    @(posedge i_clk);
    tv <= 1'b1; tw <= 1'b1;
    n = 0;
    do begin @(posedge i_clk); n++; ta <= 21'($urandom); end while (tready && n < 40);
    tv <= 1'b0;
    chk(n < 40, 1'b1);
    n = 0;
    do begin @(posedge i_clk); n++; end while (busy && n < 400);
    chk(busy, 1'b0);
    $display("queue done");
    reg_wr(4'h0, 8'h31);
    tbl(1'b1, {20'($urandom), 1'b1}, 8'($urandom), n);
    reg_wr(4'h0, 8'h33);
    wide <= 1'b0;
    @(posedge i_clk);
    tv <= 1'b1;
    tw <= 1'b1;
    ta <= 21'h0a5c3;
    td <= 8'h3c;
    @(posedge i_clk);
    tv <= 1'b0;
    step(h, 0);
    chk({up, hi, lo}, 20'h0a5c3);
    step(h, 1);
    chk({lo, cp[3:2]}, {8'h3c, 2'h2});
    step(h, 2);
    wide <= 1'b1;
    $display("modes done");
    reset(xmb_amode_mcu);
    reg_wr(4'h0, 8'hb3);
    reg_rd(4'h0, 8'h00);
    repeat (2) @(posedge i_clk);
    $display("mcu mode done");
    final_report();
  end
endmodule
